// ==== core/sys_bus_pkg.sv ====
package sys_bus_pkg;
    // ==========================================================
    // widths
    localparam int ADDR_W   = 34;
    localparam int BE_W     = 4;
    localparam int DATA_W   = 32;
    // ==========================================================
    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 34'h0_0000_0000;
    localparam logic [BE_W-1:0]   BE_RST   = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
    // ==========================================================
    // timing: read data first sampled this many clocks after accept
    localparam int RD_SAMPLE_DELAY = 1;
    // write fault follows write-data-accept by this many clocks
    localparam int WR_FAULT_DELAY  = 1;
    // read phase tracker width in bits for outstanding reads
    localparam int RD_TRACK_W      = 4;
    localparam logic [RD_TRACK_W-1:0] RD_TRACK_RST = 4'h0;
    localparam logic [RD_TRACK_W-1:0] RD_TRACK_ONE = 4'h1;
    localparam logic [1:0] WR_TRACK_RST = 2'h0;
    localparam logic [1:0] WR_TRACK_ONE = 2'h1;
endpackage : sys_bus_pkg

// ==== core/sys_bus_if.sv ====
interface sys_bus_if;
    import sys_bus_pkg::*;
    logic [ADDR_W-1:0] sysAddr;
    logic [BE_W-1:0]   byteLaneEn;
    logic              addrAccept;
    logic              fetchFlag;
    logic              addrValidOut;
    logic              wrFlag;
    logic [DATA_W-1:0] rdWord;
    logic              rdWordValid;
    logic              rdFault;
    logic [DATA_W-1:0] wrWord;
    logic              wrWordAccept;
    logic              wrFault;

    modport master (
        output sysAddr, byteLaneEn, fetchFlag, addrValidOut, wrFlag,
        output wrWord,
        input  addrAccept, rdWord, rdWordValid, rdFault,
        input  wrWordAccept, wrFault
    );
    modport target (
        input  sysAddr, byteLaneEn, fetchFlag, addrValidOut, wrFlag,
        input  wrWord,
        output addrAccept, rdWord, rdWordValid, rdFault,
        output wrWordAccept, wrFault
    );
endinterface : sys_bus_if

// ==== core/phase_count.sv ====
// ==========================================================
// outstanding-phase counter shared by both ends
module phase_count #(
    parameter int W = 4
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         inc,
    input  wire logic         dec,
    output logic [W-1:0]      count
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (inc && !dec) begin
            count_nxt = count_r + W'(1);
        end else if (dec && !inc) begin
            count_nxt = count_r - W'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;
endmodule : phase_count

// ==== core/bus_master_end.sv ====
module bus_master_end
    import sys_bus_pkg::*;
(
    input  wire logic                         clock,
    input  wire logic                         rst,
    sys_bus_if.master                         bus,
    input  wire logic                         reqValid,
    output logic                              reqReady,
    input  wire logic                         reqWrite,
    input  wire logic                         reqFetch,
    input  wire logic                         reqUncached,
    input  wire logic [sys_bus_pkg::ADDR_W-1:0] reqAddr,
    input  wire logic [sys_bus_pkg::BE_W-1:0] reqBe,
    input  wire logic [sys_bus_pkg::DATA_W-1:0] reqData,
    output logic                              rdDone,
    output logic [sys_bus_pkg::DATA_W-1:0]    rdData,
    output logic                              rdErr,
    output logic                              wrDone,
    output logic                              wrErr
);
    import sys_bus_pkg::*;

    // ==========================================================
    // address phase
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [BE_W-1:0]   be_r;
    logic [BE_W-1:0]   be_nxt;
    logic              avalid_r;
    logic              avalid_nxt;
    logic              write_r;
    logic              write_nxt;
    logic              fetch_r;
    logic              fetch_nxt;
    logic              addrTaken;
    logic              addrFree;
    logic              wdataBusy;
    logic              wdataFree;
    logic              wrBlocked;
    logic              rdBlocked;
    logic [RD_TRACK_W-1:0] rdPending;

    // the address bus is free once the current one is accepted
    assign addrTaken = avalid_r && bus.addrAccept;
    assign addrFree  = !avalid_r || addrTaken;
    // a write must also find the write data path free
    assign wrBlocked = reqWrite && wdataBusy && !wdataFree;
    // the read tracker is four bits wide: stop issuing reads at 14
    // outstanding so the read waiting in the address register fits
    assign rdBlocked = !reqWrite && (rdPending[RD_TRACK_W-1:1] == '1);
    assign reqReady  = addrFree && !wrBlocked && !rdBlocked;

    always_comb begin
        addr_nxt   = addr_r;
        be_nxt     = be_r;
        avalid_nxt = avalid_r;
        write_nxt  = write_r;
        fetch_nxt  = fetch_r;
        if (addrTaken) begin
            avalid_nxt = 1'b0;
            write_nxt  = 1'b0;
            fetch_nxt  = 1'b0;
        end
        if (reqValid && reqReady) begin
            addr_nxt   = reqAddr;
            be_nxt     = reqBe;
            avalid_nxt = 1'b1;
            write_nxt  = reqWrite;
            fetch_nxt  = !reqWrite && reqFetch && reqUncached;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            addr_r   <= ADDR_RST;
            be_r     <= BE_RST;
            avalid_r <= 1'b0;
            write_r  <= 1'b0;
            fetch_r  <= 1'b0;
        end else begin
            addr_r   <= addr_nxt;
            be_r     <= be_nxt;
            avalid_r <= avalid_nxt;
            write_r  <= write_nxt;
            fetch_r  <= fetch_nxt;
        end
    end

    assign bus.sysAddr      = addr_r;
    assign bus.byteLaneEn   = be_r;
    assign bus.addrValidOut = avalid_r;
    assign bus.wrFlag       = write_r;
    assign bus.fetchFlag    = fetch_r;

    // ==========================================================
    // read data path: in-order count of accepted reads
    logic                  rdAccepted;
    logic                  rdBeat;

    // a read accepted this edge is sampled from the next edge on
    assign rdAccepted = addrTaken && !write_r;
    assign rdBeat     = (rdPending != RD_TRACK_RST)
                        && bus.rdWordValid;

    phase_count #(.W(RD_TRACK_W)) u_rd_count (
        .clock (clock),
        .rst   (rst),
        .inc   (rdAccepted),
        .dec   (rdBeat),
        .count (rdPending)
    );

    logic [DATA_W-1:0] rdData_r, rdData_nxt;
    logic              rdDone_r, rdDone_nxt;
    logic              rdErr_r, rdErr_nxt;

    always_comb begin
        rdData_nxt = rdData_r;
        rdDone_nxt = rdBeat;
        rdErr_nxt  = rdBeat && bus.rdFault;
        if (rdBeat) begin
            rdData_nxt = bus.rdWord;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rdData_r <= DATA_RST;
            rdDone_r <= 1'b0;
            rdErr_r  <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            rdDone_r <= rdDone_nxt;
            rdErr_r  <= rdErr_nxt;
        end
    end

    assign rdData = rdData_r;
    assign rdDone = rdDone_r;
    assign rdErr  = rdErr_r;

    // ==========================================================
    // write data path: one word in flight keeps the design simple;
    // a second write waits until the first word is accepted
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic              wbusy_r, wbusy_nxt;
    logic              wfault_wait_r, wfault_wait_nxt;
    logic              wrDone_r, wrDone_nxt;
    logic              wrErr_r, wrErr_nxt;

    assign wdataBusy = wbusy_r;
    assign wdataFree = wbusy_r && bus.wrWordAccept;

    always_comb begin
        wdata_nxt       = wdata_r;
        wbusy_nxt       = wbusy_r;
        wfault_wait_nxt = wdataFree;
        // the fault line is only valid in the clock after accept
        wrDone_nxt      = wfault_wait_r;
        wrErr_nxt       = wfault_wait_r && bus.wrFault;
        if (wdataFree) begin
            wbusy_nxt = 1'b0;
        end
        if (reqValid && reqReady && reqWrite) begin
            wdata_nxt = reqData;
            wbusy_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wdata_r       <= DATA_RST;
            wbusy_r       <= 1'b0;
            wfault_wait_r <= 1'b0;
            wrDone_r      <= 1'b0;
            wrErr_r       <= 1'b0;
        end else begin
            wdata_r       <= wdata_nxt;
            wbusy_r       <= wbusy_nxt;
            wfault_wait_r <= wfault_wait_nxt;
            wrDone_r      <= wrDone_nxt;
            wrErr_r       <= wrErr_nxt;
        end
    end

    assign bus.wrWord = wdata_r;
    // registered, so completion trails the fault clock by one
    assign wrDone = wrDone_r;
    assign wrErr  = wrErr_r;
endmodule : bus_master_end

// ==== core/bus_target_end.sv ====
// ==========================================================
// far end: accepts addresses, returns read data, takes write data
module bus_target_end
    import sys_bus_pkg::*;
(
    input  wire logic                           clock,
    input  wire logic                           rst,
    sys_bus_if.target                           bus,
    input  wire logic                           addrReady,
    input  wire logic                           wdataReady,
    input  wire logic                           wdataErr,
    input  wire logic                           rspValid,
    input  wire logic [sys_bus_pkg::DATA_W-1:0] rspData,
    input  wire logic                           rspErr,
    output logic                                rspTaken,
    output logic                                cmdSeen,
    output logic [sys_bus_pkg::ADDR_W-1:0]      cmdAddr,
    output logic [sys_bus_pkg::BE_W-1:0]        cmdBe,
    output logic                                cmdWrite,
    output logic                                cmdFetch,
    output logic [sys_bus_pkg::DATA_W-1:0]      wrData,
    output logic                                wrSeen
);
    import sys_bus_pkg::*;

    // ==========================================================
    // address acceptance
    logic              addrTaken;
    logic              cmdSeen_r, cmdSeen_nxt;
    logic [ADDR_W-1:0] cmdAddr_r, cmdAddr_nxt;
    logic [BE_W-1:0]   cmdBe_r, cmdBe_nxt;
    logic              cmdWrite_r, cmdWrite_nxt;
    logic              cmdFetch_r, cmdFetch_nxt;

    assign bus.addrAccept = addrReady;
    assign addrTaken      = bus.addrValidOut && addrReady;

    always_comb begin
        cmdSeen_nxt  = addrTaken;
        cmdAddr_nxt  = cmdAddr_r;
        cmdBe_nxt    = cmdBe_r;
        cmdWrite_nxt = cmdWrite_r;
        cmdFetch_nxt = cmdFetch_r;
        if (addrTaken) begin
            cmdAddr_nxt  = bus.sysAddr;
            cmdBe_nxt    = bus.byteLaneEn;
            cmdWrite_nxt = bus.wrFlag;
            cmdFetch_nxt = bus.fetchFlag;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cmdSeen_r  <= 1'b0;
            cmdAddr_r  <= ADDR_RST;
            cmdBe_r    <= BE_RST;
            cmdWrite_r <= 1'b0;
            cmdFetch_r <= 1'b0;
        end else begin
            cmdSeen_r  <= cmdSeen_nxt;
            cmdAddr_r  <= cmdAddr_nxt;
            cmdBe_r    <= cmdBe_nxt;
            cmdWrite_r <= cmdWrite_nxt;
            cmdFetch_r <= cmdFetch_nxt;
        end
    end

    assign cmdSeen  = cmdSeen_r;
    assign cmdAddr  = cmdAddr_r;
    assign cmdBe    = cmdBe_r;
    assign cmdWrite = cmdWrite_r;
    assign cmdFetch = cmdFetch_r;

    // ==========================================================
    // read return: only for reads already accepted, in order
    logic [RD_TRACK_W-1:0] rdPending;
    logic                  rdBeat;

    assign rdBeat = (rdPending != RD_TRACK_RST) && rspValid;

    phase_count #(.W(RD_TRACK_W)) u_rd_count (
        .clock (clock),
        .rst   (rst),
        .inc   (addrTaken && !bus.wrFlag),
        .dec   (rdBeat),
        .count (rdPending)
    );

    assign bus.rdWordValid = rdBeat;
    assign bus.rdWord      = rspData;
    assign bus.rdFault     = rdBeat && rspErr;
    assign rspTaken        = rdBeat;

    // ==========================================================
    // write data acceptance and delayed fault
    logic [1:0]        wrPending;
    logic              wdTaken;
    logic              wfault_r, wfault_nxt;
    logic [DATA_W-1:0] wrData_r, wrData_nxt;
    logic              wrSeen_r, wrSeen_nxt;

    assign wdTaken = (wrPending != WR_TRACK_RST) && wdataReady;

    phase_count #(.W(2)) u_wr_count (
        .clock (clock),
        .rst   (rst),
        .inc   (addrTaken && bus.wrFlag),
        .dec   (wdTaken),
        .count (wrPending)
    );

    assign bus.wrWordAccept = wdTaken;

    always_comb begin
        wfault_nxt = wdTaken && wdataErr;
        wrSeen_nxt = wdTaken;
        wrData_nxt = wdTaken ? bus.wrWord : wrData_r;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wfault_r <= 1'b0;
            wrSeen_r <= 1'b0;
            wrData_r <= DATA_RST;
        end else begin
            wfault_r <= wfault_nxt;
            wrSeen_r <= wrSeen_nxt;
            wrData_r <= wrData_nxt;
        end
    end

    assign bus.wrFault = wfault_r;
    assign wrData      = wrData_r;
    assign wrSeen      = wrSeen_r;
endmodule : bus_target_end

// ==== sim/bus_bridge_props.sv ====
module bus_bridge_props
    import sys_bus_pkg::*;
(
    input wire logic                        clock,
    input wire logic                        rst,
    input wire logic [sys_bus_pkg::ADDR_W-1:0] sysAddr,
    input wire logic [sys_bus_pkg::BE_W-1:0]   byteLaneEn,
    input wire logic                        addrAccept,
    input wire logic                        fetchFlag,
    input wire logic                        addrValidOut,
    input wire logic                        wrFlag,
    input wire logic                        rdWordValid,
    input wire logic                        rdFault,
    input wire logic [sys_bus_pkg::DATA_W-1:0] wrWord,
    input wire logic                        wrWordAccept,
    input wire logic                        wrFault
);
    timeunit 1ns;
    timeprecision 1ns;
    import sys_bus_pkg::*;
    // ==========================================================
    // reads accepted but not yet answered
    logic [3:0] rdOut_r;
    logic [3:0] rdOut_nxt;
    logic       rdTake;
    always_comb begin
        rdTake    = addrValidOut && addrAccept && !wrFlag;
        rdOut_nxt = rdOut_r + {3'h0, rdTake} - {3'h0, rdWordValid};
    end
    always_ff @(posedge clock) begin
        rdOut_r <= rst ? 4'h0 : rdOut_nxt;
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_RST_QUIET: assert property ($fell(rst) |-> !addrValidOut && !wrFlag)
        else $error("bus active right after reset");
    AST_ADDR_HOLD: assert property (addrValidOut && !addrAccept |=>
        addrValidOut && $stable(sysAddr) && $stable(byteLaneEn))
        else $error("address moved before accept");
    AST_WR_HOLD: assert property (addrValidOut && wrFlag && !addrAccept
        |=> wrFlag && $stable(wrWord))
        else $error("write phase moved before accept");
    AST_FETCH_READ: assert property (fetchFlag && addrValidOut |-> !wrFlag)
        else $error("fetch flag on a write");
    AST_WR_NOFETCH: assert property (addrValidOut && wrFlag |-> !fetchFlag)
        else $error("write marked as fetch");
    AST_WFAULT_POS: assert property (wrFault |-> $past(wrWordAccept))
        else $error("write fault not one clock after accept");
    AST_RFAULT_VAL: assert property (rdFault |-> rdWordValid)
        else $error("read fault without read valid");
    AST_RVAL_AFTER: assert property (rdWordValid |-> rdOut_r != 4'h0)
        else $error("read data with no accepted read");
    // ==========================================================
    cover property (rdTake ##1 !rdWordValid ##1 rdWordValid);
    cover property (addrValidOut && wrFlag && addrAccept);
    cover property (rdFault);
    cover property (wrFault);
endmodule : bus_bridge_props

// ==== sim/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sys_bus_pkg::*;
    // ==========================================================
    // mismatch counters and compare
    int miscompares = 0;
    int testsRun    = 0;
    `define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin \
        miscompares++; \
        $display("unexpected at %0t: got %h expected %h", $time, a, b); \
        end end
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reqValid = 1'b0, reqWrite = 1'b0, reqFetch = 1'b0;
    logic reqUncached = 1'b0, rdDone, rdErr, wrDone, wrErr, reqReady;
    logic [ADDR_W-1:0] reqAddr = 34'h0_0000_0000, cmdAddr;
    logic [BE_W-1:0]   reqBe = 4'h0, cmdBe;
    logic [DATA_W-1:0] reqData = 32'h0, rdData, rspData = 32'hFFFF_FFFF;
    logic [DATA_W-1:0] wrData;
    logic addrReady = 1'b0, wdataReady = 1'b0, wdataErr = 1'b0;
    logic rspValid = 1'b0, rspErr = 1'b0, cmdWrite, cmdFetch;
    logic rspTaken, cmdSeen, wrSeen;
    int   rspTakes = 0;
    initial forever #25 clock = ~clock;
    sys_bus_if bus ();
    bus_master_end bus_master_end_i (.clock(clock), .rst(rst), .bus(bus),
        .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
        .reqFetch(reqFetch), .reqUncached(reqUncached), .reqAddr(reqAddr),
        .reqBe(reqBe), .reqData(reqData), .rdDone(rdDone), .rdData(rdData),
        .rdErr(rdErr), .wrDone(wrDone), .wrErr(wrErr));
    bus_target_end bus_target_end_i (.clock(clock), .rst(rst), .bus(bus),
        .addrReady(addrReady), .wdataReady(wdataReady), .wdataErr(wdataErr),
        .rspValid(rspValid), .rspData(rspData), .rspErr(rspErr),
        .rspTaken(rspTaken), .cmdSeen(cmdSeen), .cmdAddr(cmdAddr),
        .cmdBe(cmdBe), .cmdWrite(cmdWrite), .cmdFetch(cmdFetch),
        .wrData(wrData), .wrSeen(wrSeen));
    // read beats passed on by the far end, counted on the taking edge
    always @(posedge clock) begin
        if (rspTaken === 1'b1) begin
            rspTakes <= rspTakes + 1;
        end
    end
    bus_bridge_props bus_bridge_props_i (.clock(clock), .rst(rst),
        .sysAddr(bus.sysAddr), .byteLaneEn(bus.byteLaneEn),
        .addrAccept(bus.addrAccept), .fetchFlag(bus.fetchFlag),
        .addrValidOut(bus.addrValidOut), .wrFlag(bus.wrFlag),
        .rdWordValid(bus.rdWordValid), .rdFault(bus.rdFault),
        .wrWord(bus.wrWord), .wrWordAccept(bus.wrWordAccept),
        .wrFault(bus.wrFault));
    // ==========================================================
    // one transfer; aw/dw stall the address and data paths
    task automatic xfer(input logic wr, input logic fe, input logic un,
                        input logic [ADDR_W-1:0] a, input logic [BE_W-1:0] be,
                        input logic [DATA_W-1:0] d, input int aw,
                        input int dw, input logic er);
        int n;
        begin
            n = 0;
            {reqWrite, reqFetch, reqUncached} = {wr, fe, un};
            {reqAddr, reqBe, reqData, reqValid} = {a, be, d, 1'b1};
            // request stands until the address register shows it
            do begin
                @(negedge clock);
                n++;
            end while (bus.sysAddr !== a && n < 20);
            reqValid = 1'b0;
            `CHK(n, 1)
            for (int i = 0; i <= aw; i++) begin
                `CHK(bus.addrValidOut, 1'b1)
                `CHK(bus.sysAddr, a)
                `CHK(bus.byteLaneEn, be)
                `CHK(bus.wrFlag, wr)
                `CHK(bus.fetchFlag, fe & un & ~wr)
                if (wr) `CHK(bus.wrWord, d)
                addrReady = (i == aw);
                @(negedge clock);
            end
            addrReady = 1'b0;
            `CHK(cmdSeen, 1'b1)
            `CHK(bus.addrValidOut, 1'b0)
            // idle response lines carry a changing pattern, not the word
            repeat (dw) begin
                rspData = ~rspData;
                @(negedge clock);
            end
            {wdataReady, wdataErr} = {wr, er & wr};
            {rspValid, rspData, rspErr} = {~wr, d, er & ~wr};
            @(negedge clock);
            `CHK(bus.rdWordValid, 1'b0)
            `CHK(rspTaken, 1'b0)
            {wdataReady, wdataErr, rspValid, rspErr} = 4'h0;
            rspData = ~d;
            if (wr) begin
                `CHK(wrSeen, 1'b1)
                `CHK(wrData, d)
                @(negedge clock);
                `CHK(wrDone, 1'b1)
                `CHK(wrErr, er)
            end else begin
                `CHK(rdDone, 1'b1)
                `CHK(rdData, d)
                `CHK(rdErr, er)
            end
            `CHK(cmdAddr, a)
            `CHK(cmdBe, be)
            `CHK(cmdWrite, wr)
            `CHK(cmdFetch, fe & un & ~wr)
        end
    endtask : xfer
    // ==========================================================
    task automatic stop_test;
        begin
            $display("compares %0d mismatches %0d", testsRun, miscompares);
            if (miscompares == 0 && testsRun > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask : stop_test
    initial begin
        repeat (2000) @(posedge clock);
        miscompares++;
        stop_test();
    end
    initial begin
        repeat (20) @(negedge clock);
        rst = 1'b0;
        `CHK(bus.addrValidOut, 1'b0)
        `CHK(bus.wrFlag, 1'b0)
        // every fetch/uncached mix, both directions, varied stalls
        for (int k = 0; k < 8; k++) begin
            xfer(k[0], k[1], k[2], 34'h2_5A5A_0000 | 34'(k),
                 4'h1 << k[1:0], 32'hC3A5_0000 | 32'(k), k % 3,
                 (k * 2) % 3, k[1] ^ k[2]);
        end
        `CHK(rspTakes, 4)
        stop_test();
    end
endmodule : tb_top
